// [acq_pkg.sv]
// Constants for the peak converter acquisition control.
// Assumes a single 125 MHz clock and a 32-bit register port.
package acq_pkg;

  // Channels and converter
  localparam int NUM_CH   = 32;
  localparam int CH_W     = 5;
  localparam int ADC_W    = 12;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 8;
  localparam int TERM_W   = 6;

  // Timing
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int CONV_TIME_NS   = 10000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int SLOT_CYCLES    = CONV_CYCLES / NUM_CH;
  localparam int US_NS          = 1000;
  localparam int US_CYCLES      = (US_NS * 1000) / CLK_PERIOD_PS;
  localparam int FCW_MIN_US     = 10;
  localparam int FCW_MAX_US     = 35;
  localparam int POWERON_MS     = 140;
  localparam int POWERON_CYCLES = (POWERON_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int RESET_BUSY_CYCLES = 8;
  localparam int DTACK_LED_US      = 10;
  localparam int DTACK_LED_CYCLES  = DTACK_LED_US * US_CYCLES;

  // Event buffer
  localparam int BUF_AW    = 8;
  localparam int BUF_DEPTH = 256;
  localparam int EVT_WORDS = NUM_CH + 1;
  localparam int W_VALID   = 31;
  localparam int W_LAST    = 30;
  localparam int W_CH_LSB  = 16;

  // Bus address modifiers
  localparam logic [5:0] AM_GEO   = 6'h2f;
  localparam logic [5:0] AM_A24_D = 6'h39;
  localparam logic [5:0] AM_A24_B = 6'h3b;
  localparam logic [5:0] AM_A32_D = 6'h09;
  localparam logic [5:0] AM_A32_B = 6'h0b;

  // Register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_KILL     = 8'h04;
  localparam logic [7:0] REG_FCW      = 8'h08;
  localparam logic [7:0] REG_BASE_UP  = 8'h0c;
  localparam logic [7:0] REG_BASE_LO  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_EVCNT    = 8'h18;
  localparam logic [7:0] REG_DATA     = 8'h1c;
  localparam logic [7:0] REG_THR_BASE = 8'h80;

  // Control register fields and reset values
  localparam int CTRL_SUPP     = 0;
  localparam int CTRL_CNT_ALL  = 1;
  localparam int CTRL_RST_REGS = 2;
  localparam int CTRL_MEMTEST  = 3;
  localparam int CTRL_BASE_REG = 4;
  localparam logic [4:0] CTRL_RESET = 5'h01;
  localparam logic [4:0] FCW_RESET  = 5'h00;

endpackage

// [pulse_stretch.sv]
// Stretches a one-cycle trigger into a level held for CYCLES clocks.
// Assumes trig is synchronous to clock.
`timescale 1ns/100ps
module pulse_stretch #(
  parameter int CYCLES = 8
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Trigger and stretched level
  input  wire logic trig,
  output logic      level_q
);
  logic [15:0] cnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q   <= 16'h0000;
      level_q <= 1'b0;
    end else if (trig) begin
      cnt_q   <= 16'(CYCLES - 1);
      level_q <= 1'b1;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else begin
      level_q <= 1'b0;
    end
  end
endmodule // pulse_stretch

// [sdp_mem.sv]
// Simple dual-port memory with registered read data.
// Assumes one clock; read and write may address any word each cycle.
`timescale 1ns/100ps
module sdp_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  // Clock
  input  wire logic          clock,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    rdata_q <= mem[raddr];
  end
endmodule // sdp_mem

// [peak_acq_ctrl.sv]
// Acquisition control for a 32-channel peak-sensing converter.
// Assumes control pins synchronous to clock and a single shared 12-bit converter.
// Summary of operation
// - Scan all 32 peak outputs through one converter within 10 us.
// - With suppression on, keep only values above threshold and not overflowed.
// - Killed channels store nothing.
// - Peaks are detected only while the acquisition window is high.
// - Fast clear accepted from window lead to programmable 10..35 us past trail.
// - Accepted fast clear aborts conversion; nothing of that event stored.
// - Reset input clears peaks, buffer, pending conversion, optionally registers.
// - Conversion inhibit before the scan starts prevents converting any channel.
// - Busy when buffer full, converting, resetting or in memory test.
// - Data ready while at least one complete event is buffered.
// - Busy and ready lamps lit during power-on configuration.
// - Termination lamp green all, red none, dark when mixed.
// - Acknowledge lamp pulses on each bus acknowledge.
// - 24-bit event counter counts accepted or all triggers.
// - Trigger accepted only with inhibit, fast clear and busy inactive.
// - Host sets per-channel thresholds and suppression enable.
// - Host lengthens delay from window trail to conversion start.
// - Slot number latched from aux connector at every reset.
// - Slot addressing only with address modifier 0x2f, A24.
// - Base address from rotary switches or two decoder registers.
// - Respond to A24 and A32 addressing cycles.
`timescale 1ns/100ps
module peak_acq_ctrl
  import acq_pkg::*;
#(
  parameter int POWERON_CYC = acq_pkg::POWERON_CYCLES
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Register port
  input  wire logic [acq_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [acq_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [acq_pkg::DATA_W-1:0]   reg_rdata,
  // Control bus
  input  wire logic                         window_in,
  input  wire logic                         fast_clear_input,
  input  wire logic                         reset_input,
  input  wire logic                         conversion_inhibit,
  output logic                              busy_out,
  output logic                              event_available_out,
  // Peak sections and converter
  output logic                              peak_enable,
  output logic                              peak_clear,
  output logic      [acq_pkg::CH_W-1:0]     mux_sel,
  output logic                              adc_start,
  input  wire logic [acq_pkg::ADC_W-1:0]    adc_data,
  input  wire logic                         adc_overflow,
  // Bus address decode
  input  wire logic [5:0]                   vme_am,
  input  wire logic [31:16]                 vme_addr,
  input  wire logic                         vme_dtack,
  output logic                              board_selected,
  output logic                              slot_selected,
  // Crate slot and switches
  input  wire logic [acq_pkg::CH_W-1:0]     aux_connector,
  input  wire logic [15:0]                  base_switches,
  input  wire logic [acq_pkg::TERM_W-1:0]   term_status,
  // Indicators
  output logic                              dtack_led,
  output logic                              busy_led,
  output logic                              ready_led,
  output logic                              term_led_green,
  output logic                              term_led_red
);
  import acq_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_GATE, S_DELAY, S_CONV, S_COMMIT} state_t;

  function automatic logic addr_hit(input logic [5:0] am, input logic [5:0] a,
                                    input logic [5:0] b);
    addr_hit = (am == a) || (am == b);
  endfunction

  state_t                  state_q;
  logic [4:0]              ctrl_q;
  logic [NUM_CH-1:0]       kill_q;
  logic [4:0]              fcw_q;
  logic [7:0]              base_up_q;
  logic [7:0]              base_lo_q;
  logic [CH_W-1:0]         slot_q;
  logic [23:0]             evcnt_q;
  logic                    window_q;
  logic [6:0]              us_cnt_q;
  logic [5:0]              delay_q;
  logic [5:0]              slot_cnt_q;
  logic [CH_W-1:0]         ch_q;
  logic [BUF_AW:0]         wr_q;
  logic [BUF_AW:0]         wr_commit_q;
  logic [BUF_AW:0]         rd_q;
  logic [BUF_AW:0]         rd_d;
  logic [BUF_AW:0]         events_q;
  logic [24:0]             por_q;
  logic                    config_q;
  logic                    buf_we;
  logic [DATA_W-1:0]       buf_wdata;
  logic [DATA_W-1:0]       buf_rdata;
  logic [ADC_W-1:0]        thr_rdata;
  logic                    thr_we;
  logic                    rbusy;
  logic                    dtack_hold;
  logic                    win_rise;
  logic                    win_fall;
  logic                    accepted;
  logic                    abort;
  logic                    us_tick;
  logic                    slot_end;
  logic                    keep;
  logic                    full;
  logic                    pop;
  logic                    pop_last;
  logic [BUF_AW:0]         used;
  logic [15:0]             base;

  // Window edges and acceptance
  assign win_rise = window_in && !window_q;
  assign win_fall = !window_in && window_q;
  assign accepted = win_rise && !conversion_inhibit && !fast_clear_input && !busy_out;
  assign abort    = (state_q == S_GATE || state_q == S_DELAY)
                    && (fast_clear_input || conversion_inhibit);
  assign us_tick  = (us_cnt_q == 7'(US_CYCLES - 1));
  assign slot_end = (slot_cnt_q == 6'(SLOT_CYCLES - 1));
  assign used     = wr_commit_q - rd_q;
  assign full     = used > (BUF_AW+1)'(BUF_DEPTH - EVT_WORDS);
  assign pop      = reg_rd && (reg_addr == REG_DATA) && (events_q != '0);
  assign pop_last = pop && buf_rdata[W_LAST];
  assign rd_d     = pop ? rd_q + 1'b1 : rd_q;
  assign thr_we   = reg_wr && (reg_addr >= REG_THR_BASE);
  assign base     = ctrl_q[CTRL_BASE_REG] ? {base_up_q, base_lo_q} : base_switches;

  assign keep = !kill_q[ch_q] && (!ctrl_q[CTRL_SUPP]
                || (adc_data > thr_rdata && !adc_overflow));
  assign buf_we = (state_q == S_CONV && slot_end && keep) || state_q == S_COMMIT;
  assign buf_wdata = (state_q == S_COMMIT)
                     ? {2'b11, 30'h0}
                     : {1'b1, 1'b0, 9'h000, ch_q, 4'h0, adc_data};

  sdp_mem #(.AW(BUF_AW), .DW(DATA_W)) event_buffer (
    .clock   (clock),
    .we      (buf_we),
    .waddr   (wr_q[BUF_AW-1:0]),
    .wdata   (buf_wdata),
    .raddr   (rd_d[BUF_AW-1:0]),
    .rdata_q (buf_rdata)
  );

  sdp_mem #(.AW(CH_W), .DW(ADC_W)) thresholds (
    .clock   (clock),
    .we      (thr_we),
    .waddr   (reg_addr[6:2]),
    .wdata   (reg_wdata[ADC_W-1:0]),
    .raddr   (ch_q),
    .rdata_q (thr_rdata)
  );

  pulse_stretch #(.CYCLES(RESET_BUSY_CYCLES)) reset_stretch (
    .clock   (clock),
    .rst     (rst),
    .trig    (reset_input),
    .level_q (rbusy)
  );

  pulse_stretch #(.CYCLES(DTACK_LED_CYCLES)) dtack_stretch (
    .clock   (clock),
    .rst     (rst),
    .trig    (vme_dtack),
    .level_q (dtack_hold)
  );

  // Microsecond enable divider
  always_ff @(posedge clock) begin
    if (rst || state_q != S_DELAY || us_tick) begin
      us_cnt_q <= 7'h00;
    end else begin
      us_cnt_q <= us_cnt_q + 7'h01;
    end
  end

  // Acquisition sequence
  always_ff @(posedge clock) begin
    window_q <= rst ? 1'b0 : window_in;
    if (rst || reset_input) begin
      state_q    <= S_IDLE;
      slot_cnt_q <= 6'h00;
      ch_q       <= '0;
      delay_q    <= 6'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (accepted) begin
            state_q <= S_GATE;
          end
        end
        S_GATE: begin
          if (abort) begin
            state_q <= S_IDLE;
          end else if (win_fall) begin
            delay_q <= 6'(FCW_MIN_US) + ((fcw_q > 5'(FCW_MAX_US - FCW_MIN_US))
                       ? 6'(FCW_MAX_US - FCW_MIN_US) : {1'b0, fcw_q});
            state_q <= S_DELAY;
          end
        end
        S_DELAY: begin
          if (abort) begin
            state_q <= S_IDLE;
          end else if (us_tick) begin
            if (delay_q == 6'h01) begin
              state_q    <= S_CONV;
              ch_q       <= '0;
              slot_cnt_q <= 6'h00;
            end
            delay_q <= delay_q - 6'h01;
          end
        end
        S_CONV: begin
          if (slot_end) begin
            slot_cnt_q <= 6'h00;
            ch_q       <= ch_q + 1'b1;
            if (ch_q == CH_W'(NUM_CH - 1)) begin
              state_q <= S_COMMIT;
            end
          end else begin
            slot_cnt_q <= slot_cnt_q + 6'h01;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Converter and peak section drive
  always_ff @(posedge clock) begin
    if (rst) begin
      peak_enable <= 1'b0;
      peak_clear  <= 1'b0;
      adc_start   <= 1'b0;
      mux_sel     <= '0;
    end else begin
      peak_enable <= (state_q == S_GATE) && window_in && !abort;
      peak_clear  <= reset_input || abort || state_q == S_COMMIT;
      adc_start   <= (state_q == S_CONV) && (slot_cnt_q == 6'h00) && !reset_input;
      mux_sel     <= ch_q;
    end
  end

  // Buffer pointers and event count
  always_ff @(posedge clock) begin
    if (rst || reset_input) begin
      wr_q        <= '0;
      wr_commit_q <= '0;
      rd_q        <= '0;
      events_q    <= '0;
    end else begin
      rd_q <= rd_d;
      if (abort) begin
        wr_q <= wr_commit_q;
      end else if (buf_we) begin
        wr_q <= wr_q + 1'b1;
      end
      if (state_q == S_COMMIT) begin
        wr_commit_q <= wr_q + 1'b1;
      end
      events_q <= events_q + (BUF_AW+1)'(state_q == S_COMMIT) - (BUF_AW+1)'(pop_last);
    end
  end

  // Host registers
  always_ff @(posedge clock) begin
    if (rst || (reset_input && ctrl_q[CTRL_RST_REGS])) begin
      ctrl_q    <= CTRL_RESET;
      kill_q    <= '0;
      fcw_q     <= FCW_RESET;
      base_up_q <= 8'h00;
      base_lo_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_q <= reg_wdata[4:0];
      end else if (reg_addr == REG_KILL) begin
        kill_q <= reg_wdata;
      end else if (reg_addr == REG_FCW) begin
        fcw_q <= reg_wdata[4:0];
      end else if (reg_addr == REG_BASE_UP) begin
        base_up_q <= reg_wdata[7:0];
      end else if (reg_addr == REG_BASE_LO) begin
        base_lo_q <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || reset_input) begin
      slot_q <= aux_connector;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || reset_input) begin
      evcnt_q <= 24'h000000;
    end else if (accepted || (win_rise && ctrl_q[CTRL_CNT_ALL])) begin
      evcnt_q <= evcnt_q + 24'h000001;
    end
  end

  // Register read data
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        reg_rdata <= {27'h0, ctrl_q};
      end else if (reg_addr == REG_KILL) begin
        reg_rdata <= kill_q;
      end else if (reg_addr == REG_FCW) begin
        reg_rdata <= {27'h0, fcw_q};
      end else if (reg_addr == REG_BASE_UP) begin
        reg_rdata <= {24'h0, base_up_q};
      end else if (reg_addr == REG_BASE_LO) begin
        reg_rdata <= {24'h0, base_lo_q};
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata <= {19'h0, slot_q, term_led_green, term_led_red,
                      ctrl_q[CTRL_MEMTEST], full, event_available_out, busy_out,
                      config_q, 1'b0};
      end else if (reg_addr == REG_EVCNT) begin
        reg_rdata <= {8'h00, evcnt_q};
      end else if (pop) begin
        reg_rdata <= buf_rdata;
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Power-on configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      por_q    <= '0;
      config_q <= 1'b1;
    end else if (por_q == 25'(POWERON_CYC - 1)) begin
      config_q <= 1'b0;
    end else begin
      por_q <= por_q + 25'h0000001;
    end
  end

  // Status lines and indicators
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_out            <= 1'b0;
      event_available_out <= 1'b0;
      busy_led            <= 1'b1;
      ready_led           <= 1'b1;
      term_led_green      <= 1'b1;
      term_led_red        <= 1'b1;
      dtack_led           <= 1'b0;
    end else begin
      busy_out            <= full || (state_q != S_IDLE) || rbusy || reset_input
                             || ctrl_q[CTRL_MEMTEST];
      event_available_out <= (events_q != '0);
      busy_led            <= config_q || busy_out;
      ready_led           <= config_q || event_available_out;
      term_led_green      <= config_q || (&term_status);
      term_led_red        <= config_q || !(|term_status);
      dtack_led           <= dtack_hold;
    end
  end

  // Bus address decode
  always_ff @(posedge clock) begin
    if (rst) begin
      board_selected <= 1'b0;
      slot_selected  <= 1'b0;
    end else begin
      slot_selected  <= (vme_am == AM_GEO) && (vme_addr[23:19] == slot_q);
      board_selected <= (addr_hit(vme_am, AM_A24_D, AM_A24_B) && vme_addr[23:16] == base[7:0])
                        || (addr_hit(vme_am, AM_A32_D, AM_A32_B) && vme_addr[31:16] == base);
    end
  end
endmodule // peak_acq_ctrl

// [peak_acq_ctrl_checker.sv]
// Port assertions for the acquisition control.
// Assumes binding into peak_acq_ctrl, one clock, rst synchronous.
`timescale 1ns/100ps
module peak_acq_ctrl_checker
  import acq_pkg::*;
(
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       rst,
  // Register port
  input wire logic                       reg_rd,
  input wire logic [acq_pkg::DATA_W-1:0] reg_rdata,
  // Control bus
  input wire logic                       window_in,
  input wire logic                       fast_clear_input,
  input wire logic                       reset_input,
  input wire logic                       conversion_inhibit,
  input wire logic                       busy_out,
  input wire logic                       event_available_out,
  // Converter
  input wire logic                       peak_enable,
  input wire logic                       peak_clear,
  input wire logic                       adc_start,
  // Bus decode and lamps
  input wire logic [5:0]                 vme_am,
  input wire logic                       vme_dtack,
  input wire logic                       slot_selected,
  input wire logic [acq_pkg::TERM_W-1:0] term_status,
  input wire logic                       dtack_led,
  input wire logic                       term_led_green,
  input wire logic                       term_led_red
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_accept;
    $rose(window_in) && !busy_out && !conversion_inhibit && !fast_clear_input && !reset_input;
  endsequence
  a_accept_busy: assert property (
    s_accept |-> ##2 busy_out) else $error("busy missing after trigger");
  a_reset_clear: assert property (
    reset_input |=> peak_clear) else $error("peak clear missing on reset");
  a_peak_window: assert property (
    peak_enable |-> $past(window_in)) else $error("peak detect outside window");
  a_slot_spacing: assert property (
    adc_start |=> !adc_start [*8]) else $error("converter starts too close");
  a_inhibit_idle: assert property (
    conversion_inhibit && !busy_out |=> !adc_start) else $error("conversion under inhibit");
  a_term_green: assert property (
    term_led_green && !term_led_red |-> &$past(term_status)) else $error("green lamp wrong");
  a_term_red: assert property (
    term_led_red && !term_led_green |-> $past(term_status) == '0) else $error("red lamp wrong");
  a_dtack_lamp: assert property (
    $rose(vme_dtack) |-> ##[1:2] dtack_led) else $error("acknowledge lamp missing");
  a_ready_after_conv: assert property (
    $rose(event_available_out) |-> $past(busy_out, 3)) else $error("ready without event");
  a_geo_modifier: assert property (
    slot_selected |-> $past(vme_am) == AM_GEO) else $error("slot decode on wrong modifier");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside its cycle");
endmodule // peak_acq_ctrl_checker

bind peak_acq_ctrl peak_acq_ctrl_checker i_peak_acq_ctrl_checker (.*);

// [acq_frontend_model.sv]
// Gate source and converter in front of the acquisition control.
// Assumes the bench pulses fire for one clock to open a window.
`timescale 1ns/100ps
module acq_frontend_model
  import acq_pkg::*;
#(
  parameter int WIN = 20
) (
  // Clock and bench request
  input  wire logic                      clock,
  input  wire logic                      fire,
  // Window towards the control
  output logic                           window_in,
  // Converter
  input  wire logic [acq_pkg::CH_W-1:0]  mux_sel,
  output logic      [acq_pkg::ADC_W-1:0] adc_data,
  output logic                           adc_overflow
);
  int cnt_q = 0;
  always_ff @(posedge clock) begin
    if (fire) begin
      cnt_q <= WIN;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign window_in = (cnt_q != 0);
  assign adc_data     = {mux_sel, 7'h00};
  assign adc_overflow = (mux_sel == 5'h1f);
endmodule // acq_frontend_model

// [tb.sv]
// Self-checking bench for the acquisition control.
// Assumes the front-end model answers every channel select.
`timescale 1ns/100ps
module tb;
  import acq_pkg::*;
  logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, fire = 0, vme_dtack = 0;
  logic        fast_clear_input = 0, reset_input = 0, conversion_inhibit = 0;
  logic [7:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, v;
  logic [5:0]  vme_am = '0, term_status = 6'h3f;
  logic [31:16] vme_addr = '0;
  logic [4:0]  aux_connector = 5'h0b, mux_sel;
  logic [15:0] base_switches = 16'h12ab;
  logic [11:0] adc_data;
  logic        window_in, adc_overflow, busy_out, event_available_out, peak_enable;
  logic        peak_clear, adc_start, board_selected, slot_selected, dtack_led;
  logic        busy_led, ready_led, term_led_green, term_led_red;
  logic [21:0] acc [5] = '{{AM_A32_D, 16'h12ab}, {AM_A24_D, 16'h00ab},
                           {AM_A24_B, 16'h55ab}, {AM_A32_B, 16'h12ac}, {AM_GEO, 16'h0058}};
  logic [4:0]  acc_hit = 5'b11100;
  logic [5:0]  tv [2] = '{6'h00, 6'h05};
  logic [1:0]  te [2] = '{2'b01, 2'b00};
  int          miscompares = 0, checks = 0, n;

  peak_acq_ctrl #(.POWERON_CYC(20)) i_peak_acq_ctrl (.*);
  acq_frontend_model i_acq_frontend_model (.*);

  always #4 clock = ~clock;

  task automatic chk(input string what, input logic [32:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  // Kind 1 fast clears, kind 2 pin reset, in the delay after the window
  task automatic run_ev(input int kind);
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (40) @(posedge clock);
    fast_clear_input <= (kind == 1);
    reset_input      <= (kind == 2);
    @(posedge clock);
    fast_clear_input <= 1'b0;
    reset_input      <= 1'b0;
    n = 42;
    while (busy_out !== 1'b0 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    repeat (3) @(negedge clock);
  endtask
  task automatic sel(input logic [21:0] x);
    @(posedge clock);
    {vme_am, vme_addr} <= x;
    repeat (2) @(negedge clock);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #600000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("config lamps", {busy_led, ready_led}, 2'b11);
    repeat (30) @(posedge clock);
    rd(REG_STATUS);
    chk("lamps off", {busy_led, ready_led, v[1]}, 3'b000);
    chk("slot", v[12:8], 5'h0b);
    chk("term all", {term_led_green, term_led_red}, 2'b10);
    wr(8'h44, 32'h5);
    rd(8'h44);
    chk("unmapped", v, 32'h0);
    rd(REG_CTRL);
    chk("ctrl reset", v, 32'h1);
    for (int c = 0; c < 32; c++) begin
      wr(REG_THR_BASE + 8'(4 * c), 32'h200);
    end
    wr(REG_KILL, 32'h40);
    run_ev(0);
    chk("scan time", n >= 2510 && n <= 2560, 1'b1);
    chk("ready", event_available_out, 1'b1);
    for (int c = 5; c < 31; c++) begin
      if (c != 6) begin
        rd(REG_DATA);
        chk("word", v, 32'h80000000 | (c << 16) | (c << 7));
      end
    end
    rd(REG_DATA);
    chk("marker", v, 32'hc0000000);
    repeat (2) @(negedge clock);
    chk("ready gone", event_available_out, 1'b0);
    rd(REG_EVCNT);
    chk("evcnt", v, 32'h1);
    @(posedge clock);
    conversion_inhibit <= 1'b1;
    run_ev(0);
    rd(REG_EVCNT);
    chk("inhibited", {n == 42, v}, {1'b1, 32'h1});
    wr(REG_CTRL, 32'h3);
    run_ev(0);
    rd(REG_EVCNT);
    chk("count all", v, 32'h2);
    @(posedge clock);
    conversion_inhibit <= 1'b0;
    wr(REG_FCW, 32'h2);
    wr(REG_CTRL, 32'h0);
    run_ev(0);
    chk("delay time", n >= 2760 && n <= 2810, 1'b1);
    n = 0;
    while (v !== 32'hc0000000 && n < 40) begin
      rd(REG_DATA);
      n++;
    end
    chk("words", n == 32, 1'b1);
    run_ev(1);
    rd(REG_DATA);
    chk("fast_clear_input", {event_available_out, v}, 33'h0);
    wr(REG_CTRL, 32'h4);
    run_ev(2);
    rd(REG_CTRL);
    chk("pin reset", {n < 100, busy_out, event_available_out, v[4:0]}, 8'h81);
    wr(REG_CTRL, 32'h8);
    repeat (2) @(negedge clock);
    chk("memtest", busy_out, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      term_status <= tv[i];
      repeat (3) @(negedge clock);
      chk("term", {term_led_green, term_led_red}, te[i]);
    end
    @(posedge clock);
    vme_dtack <= 1'b1;
    @(posedge clock);
    vme_dtack <= 1'b0;
    repeat (2) @(negedge clock);
    chk("dtack lamp", dtack_led, 1'b1);
    for (int i = 0; i < 5; i++) begin
      sel(acc[i]);
      chk("board", board_selected, acc_hit[4 - i]);
      chk("slot sel", slot_selected, i == 4);
    end
    wr(REG_BASE_UP, 32'h34);
    wr(REG_BASE_LO, 32'h56);
    wr(REG_CTRL, 32'h10);
    sel({AM_A32_D, 16'h3456});
    chk("base regs", board_selected, 1'b1);
    wr(REG_CTRL, 32'h0);
    repeat (7) run_ev(0);
    rd(REG_STATUS);
    chk("full", {busy_out, v[4]}, 2'b11);
    n = 0;
    while (event_available_out !== 1'b0 && n < 300) begin
      rd(REG_DATA);
      n++;
    end
    repeat (3) @(negedge clock);
    chk("drained", busy_out, 1'b0);
    wrap_up();
  end
endmodule // tb
